// ==== hdl/see_array_access.v ====
// Array access and write protection logic of a serial-interface EEPROM.
//
// Overview of operation
// RQ1 - Read captures two address bytes, then shifts out the addressed byte.
// RQ2 - While selected, read address advances by one after every output byte.
// RQ3 - Read address wraps from the top location to zero.
// RQ4 - Deselect ends a read at any point without side effects.
// RQ5 - Read arriving during a program cycle is ignored.
// RQ6 - Large variant decodes 15 address bits, small variant 14.
// RQ7 - Host sends write command, address, then data bytes while selected.
// RQ8 - Deselect at a data byte boundary starts the program cycle.
// RQ9 - Program-busy flag clears when the program cycle ends.
// RQ10 - Page write wraps within the 64-byte page, later bytes overwrite.
// RQ11 - Write refused unless the arm latch is set.
// RQ12 - Write refused while a program cycle is running.
// RQ13 - Write refused when its page lies in the block-protected region.
// RQ14 - Lock bit clear: status writes allowed after arming, any pin level.
// RQ15 - Lock bit set, protect pin high: status writes allowed after arming.
// RQ16 - Lock bit set, protect pin low: every status write refused.
// RQ17 - Hardware lock entered by either order of bit set and pin low.
// RQ18 - Hardware lock left only when the protect pin returns high.
// RQ19 - Block-protect bits select none, upper quarter, upper half or all.
// RQ20 - Read code 03h and write code 02h are the first byte.
// RQ21 - Arm latch clears when a program cycle completes.
// RQ22 - Program-busy flag stays set for the whole program cycle.
// RQ23 - Inputs sampled on rising clock, outputs change on falling, MSB first.
// RQ24 - Program duration comes from a configurable cycle counter.
`timescale 1ns/1ps
`include "see_defs.vh"

module see_array_access #(
  parameter LARGE = 1,
  parameter PROG_CYCLES = `SEE_PROG_TIME_NS / `SEE_CLK_PERIOD_NS
) (
  input wire mclk,
  input wire arst_n,
  input wire sel_n,
  input wire sclk,
  input wire sdi,
  input wire wp_n,
  output reg sdo,
  output reg sdo_oe,
  output reg program_busy,
  output reg arm_latch,
  output reg protect_size_hi,
  output reg protect_size_lo,
  output reg status_lock_bit,
  output reg hardware_lock_mode
);

  localparam AW = LARGE ? `SEE_AW_LARGE : `SEE_AW_SMALL;
  localparam DEPTH = 1 << AW;
  localparam PB = `SEE_PAGE_BITS;
  localparam PS = `SEE_PAGE_SIZE;

  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_RDATA = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_SRDATA = 3'h5;
  localparam ST_RDSTAT = 3'h6;
  localparam ST_WAIT = 3'h7;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg sclk_m;
  reg sclk_s;
  reg sclk_d;
  reg sdi_m;
  reg sdi_s;
  reg sel_m;
  reg sel_s;
  reg sel_d;
  reg wp_m;
  reg wp_s;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
      sel_m <= 1'b1;
      sel_s <= 1'b1;
      sel_d <= 1'b1;
      wp_m <= 1'b1;
      wp_s <= 1'b1;
    end else begin
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sdi_m <= sdi;
      sdi_s <= sdi_m;
      sel_m <= sel_n;
      sel_s <= sel_m;
      sel_d <= sel_s;
      wp_m <= wp_n;
      wp_s <= wp_m;
    end
  end

  // Edges are found on the second stage only, so a metastable first
  // stage can never produce a double or missed serial clock edge.
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire sel_rise = sel_s & ~sel_d;
  wire sel_fall = ~sel_s & sel_d;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] pbuf [0:PS-1];
  reg [PS-1:0] pval;

  // ----------------------------------------------------------------------
  // Serial engine state
  // ----------------------------------------------------------------------
  reg [2:0] state;
  reg [3:0] cnt;
  reg [2:0] ocnt;
  reg [15:0] in_sr;
  reg [7:0] out_sr;
  reg [7:0] cmd;
  reg [AW-1:0] addr;
  reg [AW-PB-1:0] page;
  reg [PB-1:0] col;
  reg got_byte;
  reg [7:0] new_sr;
  reg prog_start;
  reg prog_status;

  wire prog_done;
  wire [15:0] next_sr = {in_sr[14:0], sdi_s};
  wire [AW-1:0] next_addr = addr + {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] cap_addr = next_sr[AW-1:0];
  wire [7:0] status_byte = {status_lock_bit, 3'h0, protect_size_hi, protect_size_lo,
                            arm_latch, program_busy};
  wire byte_in = sclk_rise & ~sel_s & (state == ST_WDATA) & (cnt[2:0] == `SEE_BIT_LAST);
  wire at_boundary = got_byte & (cnt == 4'h0);

  // ----------------------------------------------------------------------
  // Block protection decode
  // ----------------------------------------------------------------------
  function prot_hit;
    input [AW-1:0] a;
    input [1:0] bp;
    begin
      case (bp)
        `SEE_BP_NONE: prot_hit = 1'b0;
        `SEE_BP_QUARTER: prot_hit = a[AW-1] & a[AW-2];
        `SEE_BP_HALF: prot_hit = a[AW-1];
        `SEE_BP_ALL: prot_hit = 1'b1;
        default: prot_hit = 1'b1;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Program cycle timer
  // ----------------------------------------------------------------------
  see_prog_timer #(
    .CYCLES(PROG_CYCLES),
    .CW(`SEE_TIMER_W)
  ) u_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .start(prog_start),
    .done(prog_done)
  );

  // ----------------------------------------------------------------------
  // Main control
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      ocnt <= 3'h0;
      in_sr <= 16'h0000;
      out_sr <= 8'h00;
      cmd <= 8'h00;
      addr <= {AW{1'b0}};
      page <= {(AW-PB){1'b0}};
      col <= {PB{1'b0}};
      got_byte <= 1'b0;
      new_sr <= 8'h00;
      pval <= {PS{1'b0}};
      prog_start <= 1'b0;
      prog_status <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      program_busy <= 1'b0;
      arm_latch <= 1'b0;
      protect_size_hi <= 1'b0;
      protect_size_lo <= 1'b0;
      status_lock_bit <= 1'b0;
      hardware_lock_mode <= 1'b0;
    end else begin
      prog_start <= 1'b0;
      // The lock follows the pin every cycle, so only the pin can release it.
      hardware_lock_mode <= status_lock_bit & ~wp_s; // [RQ17] [RQ18]
      if (prog_done) begin
        program_busy <= 1'b0; // [RQ9]
        arm_latch <= 1'b0; // [RQ21]
        if (prog_status) begin
          status_lock_bit <= new_sr[`SEE_ST_LOCK];
          protect_size_hi <= new_sr[`SEE_ST_BP_HI];
          protect_size_lo <= new_sr[`SEE_ST_BP_LO];
        end
      end
      if (sel_rise) begin
        // Deselect always returns to idle, which aborts a read cleanly.
        state <= ST_IDLE; // [RQ4]
        sdo_oe <= 1'b0;
        if (state == ST_WDATA && at_boundary) begin
          prog_start <= 1'b1; // [RQ8]
          prog_status <= 1'b0;
          program_busy <= 1'b1; // [RQ22]
        end else if (state == ST_SRDATA && at_boundary) begin
          prog_start <= 1'b1;
          prog_status <= 1'b1;
          program_busy <= 1'b1; // [RQ22]
        end else if (state == ST_WAIT && cmd == `SEE_CMD_ARM) begin
          arm_latch <= 1'b1;
        end else if (state == ST_WAIT && cmd == `SEE_CMD_DISARM) begin
          arm_latch <= 1'b0;
        end
      end else if (sel_fall) begin
        state <= ST_CMD;
        cnt <= 4'h0;
        ocnt <= 3'h0;
        got_byte <= 1'b0;
      end else if (sclk_rise && !sel_s) begin
        in_sr <= next_sr; // [RQ23]
        cnt <= cnt + 4'h1;
        case (state)
          ST_CMD: begin
            if (cnt == `SEE_CMD_LAST) begin
              cnt <= 4'h0;
              cmd <= next_sr[7:0];
              case (next_sr[7:0])
                `SEE_CMD_READ: begin
                  state <= program_busy ? ST_IDLE : ST_ADDR; // [RQ5] [RQ20]
                end
                `SEE_CMD_WRITE: begin
                  if (program_busy || !arm_latch) begin
                    state <= ST_IDLE; // [RQ11] [RQ12]
                  end else begin
                    state <= ST_ADDR; // [RQ20]
                  end
                end
                `SEE_CMD_WRSTAT: begin
                  if (program_busy || !arm_latch || hardware_lock_mode) begin
                    state <= ST_IDLE; // [RQ16]
                  end else begin
                    state <= ST_SRDATA; // [RQ14] [RQ15]
                  end
                end
                `SEE_CMD_RDSTAT: begin
                  state <= ST_RDSTAT;
                  out_sr <= status_byte;
                  sdo_oe <= 1'b1;
                end
                `SEE_CMD_ARM, `SEE_CMD_DISARM: begin
                  state <= program_busy ? ST_IDLE : ST_WAIT;
                end
                default: begin
                  state <= ST_IDLE;
                end
              endcase
            end
          end
          ST_ADDR: begin
            if (cnt == `SEE_ADDR_LAST) begin
              cnt <= 4'h0;
              addr <= cap_addr; // [RQ1] [RQ6]
              if (cmd == `SEE_CMD_READ) begin
                state <= ST_RDATA;
                out_sr <= mem[cap_addr]; // [RQ1]
                sdo_oe <= 1'b1;
              end else if (prot_hit(cap_addr, {protect_size_hi, protect_size_lo})) begin
                state <= ST_IDLE; // [RQ13] [RQ19]
              end else begin
                state <= ST_WDATA;
                page <= cap_addr[AW-1:PB];
                col <= cap_addr[PB-1:0];
                pval <= {PS{1'b0}};
              end
            end
          end
          ST_WDATA: begin
            if (cnt[2:0] == `SEE_BIT_LAST) begin
              cnt <= 4'h0;
              pval[col] <= 1'b1;
              // Only the column advances, so the address wraps in the page.
              col <= col + {{(PB-1){1'b0}}, 1'b1}; // [RQ10]
              got_byte <= 1'b1;
            end
          end
          ST_SRDATA: begin
            if (cnt[2:0] == `SEE_BIT_LAST) begin
              cnt <= 4'h0;
              new_sr <= next_sr[7:0];
              got_byte <= 1'b1;
            end
          end
          ST_WAIT: begin
            state <= ST_IDLE;
          end
          default: begin
            cnt <= 4'h0;
          end
        endcase
      end else if (sclk_fall && !sel_s) begin
        if (state == ST_RDATA || state == ST_RDSTAT) begin
          sdo <= out_sr[7]; // [RQ23]
          out_sr <= {out_sr[6:0], 1'b0};
          ocnt <= ocnt + 3'h1;
          if (ocnt == `SEE_BIT_LAST) begin
            if (state == ST_RDATA) begin
              // Natural overflow of the address gives the wrap to zero.
              addr <= next_addr; // [RQ2] [RQ3]
              out_sr <= mem[next_addr]; // [RQ2]
            end else begin
              out_sr <= status_byte;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Page buffer and array commit
  // ----------------------------------------------------------------------
  // The array holds no reset, as a real nonvolatile store would not.
  integer i;

  always @(posedge mclk) begin
    if (byte_in) begin
      pbuf[col] <= next_sr[7:0]; // [RQ10]
    end
    if (prog_done && !prog_status) begin
      for (i = 0; i < PS; i = i + 1) begin
        if (pval[i]) begin
          mem[{page, i[PB-1:0]}] <= pbuf[i]; // [RQ10]
        end
      end
    end
  end

endmodule // see_array_access

// ==== hdl/see_defs.vh ====
// Shared constants of the serial EEPROM array access and protection block.
`ifndef SEE_DEFS_VH
`define SEE_DEFS_VH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define SEE_CMD_ARM 8'h06
`define SEE_CMD_DISARM 8'h04
`define SEE_CMD_RDSTAT 8'h05
`define SEE_CMD_WRSTAT 8'h01
`define SEE_CMD_READ 8'h03
`define SEE_CMD_WRITE 8'h02

// ----------------------------------------------------------------------
// Array geometry and serial frame bit counts
// ----------------------------------------------------------------------
`define SEE_AW_LARGE 15
`define SEE_AW_SMALL 14
`define SEE_PAGE_BITS 6
`define SEE_PAGE_SIZE 64
`define SEE_CMD_LAST 4'h7
`define SEE_ADDR_LAST 4'hF
`define SEE_BIT_LAST 3'h7

// ----------------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------------
`define SEE_ST_BUSY 0
`define SEE_ST_ARM 1
`define SEE_ST_BP_LO 2
`define SEE_ST_BP_HI 3
`define SEE_ST_LOCK 7

// ----------------------------------------------------------------------
// Block-protect encodings
// ----------------------------------------------------------------------
`define SEE_BP_NONE 2'h0
`define SEE_BP_QUARTER 2'h1
`define SEE_BP_HALF 2'h2
`define SEE_BP_ALL 2'h3

// ----------------------------------------------------------------------
// Program cycle timing
// ----------------------------------------------------------------------
`define SEE_PROG_TIME_NS 5000000
`define SEE_CLK_PERIOD_NS 25
`define SEE_TIMER_W 18

`endif

// ==== hdl/see_prog_timer.v ====
// Self-timed program cycle counter of the serial EEPROM block.
`timescale 1ns/1ps

module see_prog_timer #(
  parameter CYCLES = 200000,
  parameter CW = 18
) (
  input wire mclk,
  input wire arst_n,
  input wire start,
  output reg done
);

  reg [CW-1:0] count;
  reg running;

  // ----------------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {CW{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}; // [RQ24]
        running <= 1'b1;
      end else if (running) begin
        if (count == {CW{1'b0}}) begin
          running <= 1'b0;
          done <= 1'b1; // [RQ24]
        end else begin
          count <= count - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // see_prog_timer

// ==== testbench/see_array_access_assertions.sv ====
// Property checker bound to the serial EEPROM array access block.
`timescale 1ns/1ps
module see_chk #(
  parameter PROG_CYCLES = 20
) (
  input wire mclk,
  input wire arst_n,
  input wire sel_n,
  input wire sclk,
  input wire sdi,
  input wire wp_n,
  input wire sdo,
  input wire sdo_oe,
  input wire program_busy,
  input wire arm_latch,
  input wire protect_size_hi,
  input wire protect_size_lo,
  input wire status_lock_bit,
  input wire hardware_lock_mode
);
  // Length of the current busy run; wide enough never to wrap.
  logic [31:0] bcnt;
  always @(posedge mclk or negedge arst_n)
    if (!arst_n) bcnt <= 32'h0;
    else bcnt <= program_busy ? bcnt + 32'h1 : 32'h0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_BUSY_HOLD: assert property ($fell(program_busy) |-> bcnt >= PROG_CYCLES)
    else $error("program cycle ended early");
  AST_BUSY_END: assert property (program_busy |-> bcnt <= PROG_CYCLES + 2)
    else $error("program cycle overran");
  AST_START_DESEL: assert property ($rose(program_busy) |-> sel_n)
    else $error("cycle started while selected");
  AST_START_ARMED: assert property ($rose(program_busy) |-> arm_latch)
    else $error("cycle started unarmed");
  AST_ARM_CLEAR: assert property ($fell(program_busy) |-> ##[0:1] !arm_latch)
    else $error("arm latch kept after cycle");
  AST_NO_ARM_BUSY: assert property (program_busy |-> !$rose(arm_latch))
    else $error("arm latch set while busy");
  AST_LOCK_ENTER: assert property ((status_lock_bit && !wp_n) [*5] |-> hardware_lock_mode)
    else $error("lock mode not entered");
  AST_LOCK_LEAVE: assert property (wp_n [*5] |-> !hardware_lock_mode)
    else $error("lock mode kept with pin high");
  AST_LOCK_FROZEN: assert property (hardware_lock_mode |=>
    $stable({status_lock_bit, protect_size_hi, protect_size_lo}))
    else $error("status changed in lock mode");
  AST_OE_DESEL: assert property (sel_n [*6] |-> !sdo_oe)
    else $error("output driven while deselected");
  AST_SDO_EDGE: assert property ($changed(sdo) |-> !sclk)
    else $error("output moved with clock high");
endmodule // see_chk
bind see_array_access see_chk #(.PROG_CYCLES(PROG_CYCLES)) u_see_chk (
  .mclk(mclk), .arst_n(arst_n), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .wp_n(wp_n),
  .sdo(sdo), .sdo_oe(sdo_oe), .program_busy(program_busy), .arm_latch(arm_latch),
  .protect_size_hi(protect_size_hi), .protect_size_lo(protect_size_lo),
  .status_lock_bit(status_lock_bit), .hardware_lock_mode(hardware_lock_mode));

// ==== testbench/see_host_model.sv ====
// Serial bus host model that frames instructions for the EEPROM block.
`timescale 1ns/1ps
module see_host_model (
  input wire mclk,
  input wire sdo,
  output logic sel_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // The serial clock stands low between frames, as in mode 0.
  task automatic start_f();
    w(1);
    sel_n = 1'b0;
  endtask
  // Reply bits are taken late in the high phase, long after they settled.
  task automatic xb(input logic [7:0] d, output logic [7:0] q, input int n = 8);
    for (int i = 7; i > 7 - n; i--) begin
      sdi = d[i];
      w(4);
      sclk = 1'b1;
      w(3);
      q[i] = sdo;
      w(1);
      sclk = 1'b0;
    end
  endtask
  // The released data line is inverted so a stale level never looks valid.
  task automatic end_f();
    w(4);
    sel_n = 1'b1;
    sdi = ~sdi;
    w(8);
  endtask
endmodule // see_host_model

// ==== testbench/see_array_access_bench.sv ====
// Self-checking bench of the serial EEPROM array access block.
`timescale 1ns/1ps
`include "see_defs.vh"
module see_array_access_bench;
  localparam int PC = 400;
  logic mclk, arst_n, wp_n;
  wire sel_n, sclk, sdi, sdo, sdo_oe, program_busy, arm_latch;
  wire protect_size_hi, protect_size_lo, status_lock_bit, hardware_lock_mode;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] ref_mem [0:32767];
  logic [7:0] q;
  logic [15:0] edges [5] = '{16'h5FFF, 16'h6000, 16'h3FFF, 16'h4000, 16'h0000};
  see_array_access #(.LARGE(1), .PROG_CYCLES(PC)) u_see_array_access (
    .mclk(mclk), .arst_n(arst_n), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .wp_n(wp_n),
    .sdo(sdo), .sdo_oe(sdo_oe), .program_busy(program_busy), .arm_latch(arm_latch),
    .protect_size_hi(protect_size_hi), .protect_size_lo(protect_size_lo),
    .status_lock_bit(status_lock_bit), .hardware_lock_mode(hardware_lock_mode));
  see_host_model u_see_host_model (.mclk(mclk), .sdo(sdo), .sel_n(sel_n), .sclk(sclk),
    .sdi(sdi));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ---
  // Stimulus helpers
  // ---
  function automatic bit prot(input logic [1:0] bp, input logic [14:0] a);
    return bp == 2'h3 || (bp == 2'h2 && a[14]) || (bp == 2'h1 && a[14:13] == 2'h3);
  endfunction
  // Status byte as the host should read it back.
  function automatic logic [7:0] stat(input logic lk, input logic [1:0] bp, input logic am,
    input logic bz);
    return {lk, 3'h0, bp, am, bz};
  endfunction
  task automatic b(input logic [7:0] d, input int n = 8);
    u_see_host_model.xb(d, q, n);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] a);
    u_see_host_model.start_f();
    b(c);
    if (c == `SEE_CMD_READ || c == `SEE_CMD_WRITE) begin
      b(a[15:8]);
      b(a[7:0]);
    end
  endtask
  task automatic fin();
    u_see_host_model.end_f();
  endtask
  task automatic idle();
    for (int k = 0; k < 600 && program_busy !== 1'b0; k++) u_see_host_model.w(1);
    chk("program_busy", program_busy, 0);
    chk("arm_latch", arm_latch, 0);
  endtask
  task automatic arm();
    cmd(`SEE_CMD_ARM, 0);
    fin();
    chk("arm_latch", arm_latch, 1);
  endtask
  task automatic wr(input logic [15:0] a, input int n, input bit ok, input bit hold);
    logic [7:0] d;
    arm();
    cmd(`SEE_CMD_WRITE, a);
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      b(d);
      if (ok) ref_mem[{a[14:6], a[5:0] + i[5:0]}] = d;
    end
    fin();
    chk("program_busy", program_busy, ok);
    if (ok && !hold) idle();
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    cmd(`SEE_CMD_READ, a);
    for (int i = 0; i < n; i++) begin
      b(8'h00);
      chk("sdo_oe", sdo_oe, 1);
      chk("rdata", q, ref_mem[a[14:0] + i[14:0]]);
    end
    fin();
    chk("sdo_oe", sdo_oe, 0);
  endtask
  task automatic st(input logic [7:0] v, input bit ok);
    arm();
    cmd(`SEE_CMD_WRSTAT, 0);
    b(v);
    fin();
    chk("program_busy", program_busy, ok);
    if (ok) idle();
  endtask
  task automatic lock_chk(input logic lvl, input logic exp);
    wp_n = lvl;
    u_see_host_model.w(5);
    chk("lock_mode", hardware_lock_mode, exp);
  endtask
  // ---
  // Main sequence
  // ---
  initial begin
    logic [15:0] a;
    arst_n = 1'b0;
    wp_n = 1'b1;
    void'($urandom(32'h11c84bb9));
    repeat (10) @(posedge mclk);
    #1 arst_n = 1'b1;
    u_see_host_model.w(3);
    chk("reset", {program_busy, arm_latch, status_lock_bit, sdo_oe}, 0);
    cmd(`SEE_CMD_WRITE, 16'h0100);
    b(8'h5A);
    fin();
    chk("program_busy", program_busy, 0);
    wr(16'h7FC5, 66, 1, 0);
    wr(16'h0000, 64, 1, 0);
    wr(16'h0040, 1, 1, 1);
    cmd(`SEE_CMD_READ, 16'h0040);
    b(8'h00);
    chk("sdo_oe", sdo_oe, 0);
    fin();
    // The arm latch still stands, so only the running cycle can refuse this write.
    cmd(`SEE_CMD_WRITE, 16'h0040);
    b(8'hC3);
    fin();
    idle();
    rd(16'hFFC0, 129);
    cmd(`SEE_CMD_READ, 16'h7FD0);
    b(8'h00);
    b(8'h00, 3);
    fin();
    chk("sdo_oe", sdo_oe, 0);
    rd(16'h7FD1, 2);
    arm();
    cmd(`SEE_CMD_WRITE, 16'h0080);
    b(8'hA5);
    b(8'h3C, 3);
    fin();
    chk("program_busy", program_busy, 0);
    for (int bp = 0; bp < 4; bp++) begin
      st({4'h0, bp[1:0], 2'h0}, 1);
      chk("protect", {protect_size_hi, protect_size_lo}, bp[1:0]);
      edges[4] = $urandom;
      foreach (edges[j]) begin
        a = edges[j];
        wr(a, 1, !prot(bp[1:0], a[14:0]), 0);
      end
    end
    wp_n = 1'b0;
    st(8'h84, 1);
    lock_chk(1'b0, 1'b1);
    arm();
    cmd(`SEE_CMD_RDSTAT, 0);
    b(8'h00);
    fin();
    chk("status_read", q, stat(1'b1, 2'h1, 1'b1, 1'b0));
    cmd(`SEE_CMD_DISARM, 0);
    fin();
    chk("arm_latch", arm_latch, 0);
    st(8'h00, 0);
    chk("status", {status_lock_bit, protect_size_hi, protect_size_lo}, 3'h5);
    wr(16'h7000, 1, 0, 0);
    lock_chk(1'b1, 1'b0);
    st(8'h80, 1);
    lock_chk(1'b0, 1'b1);
    lock_chk(1'b1, 1'b0);
    st(8'h00, 1);
    chk("status", {status_lock_bit, protect_size_hi, protect_size_lo}, 3'h0);
    wr(16'h7000, 1, 1, 0);
    give_verdict();
  end
endmodule // see_array_access_bench
